// >>> hdl/pscl_loader.sv
// passive serial configuration loader: word fifo and device-side loader
`timescale 1ns/100ps

//==================================================================
// synchronous word fifo, flip-flop storage
module pscl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	// fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	wire              push;
	wire              pop;

	// full and empty straight from the occupancy count
	assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
	assign o_out_valid = (count_r != '0);
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;
	assign o_out_data  = mem_r[rd_ptr_r];

	// storage is written without reset, pointers carry the state
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	// pointers and count
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//==================================================================
// device-side loader
module pscl_loader
	import pscl_pkg::*;
#(
	parameter int IMAGE_WORDS   = 64,
	parameter int POR_CYC       = 1000,
	parameter int UM_CYC        = UM_MIN_CYC,
	parameter int SCLK_MAX_NS   = 10,
	parameter int USR_INIT_CYC  = USR_INIT_CYCLES
) (
	// core clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_b,
	// host pins
	input  wire logic              i_cfg_req_b,
	input  wire logic              i_serial_cfg_clock,
	input  wire logic              i_serial_cfg_data_in,
	output logic                   o_serial_cfg_data_out,
	output logic                   o_serial_cfg_data_oe,
	input  wire logic              i_user_init_clock,
	// open-drain status, done and init-done pins
	output logic                   o_status_out,
	output logic                   o_status_oe,
	output logic                   o_done_out,
	output logic                   o_done_oe,
	output logic                   o_init_done_out,
	output logic                   o_init_done_oe,
	// configuration word sink
	output logic                   o_word_valid,
	input  wire logic              i_word_ready,
	output logic      [WORD_W-1:0] o_word_data,
	// user side of the data pin after configuration
	input  wire logic              i_user_data_out,
	input  wire logic              i_user_data_oe,
	output logic                   o_user_data_in,
	output logic                   o_user_mode
);
	localparam int CU_CYC  = (CU_PERIODS * SCLK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WCNT_W  = $clog2(IMAGE_WORDS + 1);

	//==============================================================
	// link domain: bit capture on the serial clock
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] link_word_r;
	logic [4:0]        bit_cnt_r;
	logic [WCNT_W-1:0] link_words_r;
	logic              word_tgl_r;
	logic [1:0]        fall_cnt_r;
	logic              edges_tgl_r;
	wire               link_rst_b;
	wire               link_last;

	// a low request line empties the link side at once, clock or not
	assign link_rst_b = i_rst_b & i_cfg_req_b;
	assign link_last  = (link_words_r == WCNT_W'(IMAGE_WORDS));

	// (RULE14) one bit per rise
	always_ff @(posedge i_serial_cfg_clock or negedge link_rst_b) begin
		if (!link_rst_b) begin
			shift_r      <= '0;
			link_word_r  <= '0;
			bit_cnt_r    <= '0;
			link_words_r <= '0;
			word_tgl_r   <= 1'b0;
		end else if (!link_last) begin
			shift_r   <= {i_serial_cfg_data_in, shift_r[WORD_W-1:1]};
			bit_cnt_r <= bit_cnt_r + 1'b1;
			if (bit_cnt_r == 5'h1F) begin
				link_word_r  <= {i_serial_cfg_data_in, shift_r[WORD_W-1:1]};
				link_words_r <= link_words_r + 1'b1;
				word_tgl_r   <= ~word_tgl_r;
			end
		end
	end

	// (RULE6) two trailing falls
	always_ff @(negedge i_serial_cfg_clock or negedge link_rst_b) begin
		if (!link_rst_b) begin
			fall_cnt_r  <= '0;
			edges_tgl_r <= 1'b0;
		end else if (link_last && fall_cnt_r != 2'h2) begin
			fall_cnt_r <= fall_cnt_r + 1'b1;
			if (fall_cnt_r == 2'h1) begin
				edges_tgl_r <= 1'b1;
			end
		end
	end

	//==============================================================
	// core domain: synchronisers
	logic [1:0] req_sync_r;
	logic [2:0] word_sync_r;
	logic [1:0] edges_sync_r;
	logic [2:0] uclk_sync_r;
	logic [1:0] din_sync_r;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			req_sync_r   <= '0;
			word_sync_r  <= '0;
			edges_sync_r <= '0;
			uclk_sync_r  <= '0;
			din_sync_r   <= '0;
		end else begin
			req_sync_r   <= {req_sync_r[0], i_cfg_req_b};
			word_sync_r  <= {word_sync_r[1:0], word_tgl_r};
			edges_sync_r <= {edges_sync_r[0], edges_tgl_r};
			uclk_sync_r  <= {uclk_sync_r[1:0], i_user_init_clock};
			din_sync_r   <= {din_sync_r[0], i_serial_cfg_data_in};
		end
	end

	wire req_low   = ~req_sync_r[1];
	wire word_evt  = word_sync_r[2] ^ word_sync_r[1];
	wire edges_ok  = edges_sync_r[1];
	wire uclk_rise = uclk_sync_r[1] & ~uclk_sync_r[2];

	//==============================================================
	// word hand-over into the fifo
	logic              fifo_in_ready;
	logic              push_r;
	logic [WORD_W-1:0] push_data_r;
	logic [WCNT_W-1:0] words_r;
	logic [WORD_W-1:0] opt_r;

	// the link word is stable for 31 serial edges after its toggle,
	// far longer than the three-flop toggle path
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			push_r      <= 1'b0;
			push_data_r <= '0;
		end else begin
			push_r      <= word_evt & ~req_low;
			// capture only once the toggle says the link word is settled
			push_data_r <= word_evt ? link_word_r : push_data_r;
		end
	end

	pscl_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (push_r),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (push_data_r),
		.o_out_valid (o_word_valid),
		.i_out_ready (i_word_ready),
		.o_out_data  (o_word_data)
	);

	//==============================================================
	// sequencer
	pscl_state_t state_r;
	pscl_state_t state_nxt;
	logic [31:0] cnt_r;
	wire         overflow  = push_r & ~fifo_in_ready;
	wire         all_in    = (words_r == WCNT_W'(IMAGE_WORDS)) & ~o_word_valid;
	wire         opt_usr   = opt_r[OPT_USER_CLK_BIT];

	// next state; a low request line wins from any state but ST_POR
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// (RULE3) power-on delay
			ST_POR:      if (cnt_r == 32'(POR_CYC - 1)) state_nxt = ST_CLEAR;
			ST_CLEAR:    if (!req_low) state_nxt = ST_LOAD;
			ST_LOAD: begin
				if (overflow) begin
					state_nxt = ST_ERROR;
				// (RULE5) complete image
				end else if (all_in) begin
					state_nxt = ST_EDGES;
				end
			end
			ST_EDGES:    if (edges_ok) state_nxt = opt_usr ? ST_INIT_CU : ST_INIT_OSC;
			// (RULE10) oscillator init window
			ST_INIT_OSC: if (cnt_r == 32'(UM_CYC - 1)) state_nxt = ST_USER;
			// (RULE11) user clock enable
			ST_INIT_CU:  if (cnt_r == 32'(CU_CYC - 1)) state_nxt = ST_INIT_USR;
			// (RULE12) user clock periods
			ST_INIT_USR: if (uclk_rise && cnt_r == 32'(USR_INIT_CYC - 1)) state_nxt = ST_USER;
			ST_USER:     state_nxt = ST_USER;
			ST_ERROR:    state_nxt = ST_ERROR;
			default:     state_nxt = ST_CLEAR;
		endcase
		// (RULE1) restart on request
		if (req_low && state_r != ST_POR) begin
			state_nxt = ST_CLEAR;
		end
	end

	// state, cycle counter, received word count and option word
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r <= ST_POR;
			cnt_r   <= '0;
			words_r <= '0;
			opt_r   <= OPT_RESET;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				cnt_r <= '0;
			end else if (state_r != ST_INIT_USR || uclk_rise) begin
				cnt_r <= cnt_r + 1'b1;
			end
			if (state_r == ST_CLEAR) begin
				words_r <= '0;
				opt_r   <= OPT_RESET;
			end else if (push_r && fifo_in_ready) begin
				words_r <= words_r + 1'b1;
				if (words_r == '0) begin
					opt_r <= push_data_r;
				end
			end
		end
	end

	//==============================================================
	// pin drive; open-drain pins are only ever driven low
	logic status_low_r;
	logic done_low_r;
	logic init_low_r;
	logic user_r;
	logic dout_r;
	logic doe_r;

	// registered pin controls keep the pads glitch free
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			status_low_r <= 1'b1;
			done_low_r   <= 1'b1;
			init_low_r   <= 1'b0;
			user_r       <= 1'b0;
			dout_r       <= 1'b0;
			doe_r        <= 1'b0;
		end else begin
			// (RULE2) released in user mode
			status_low_r <= (state_nxt == ST_POR) | (state_nxt == ST_CLEAR) |
				(state_nxt == ST_ERROR);
			// (RULE4) done low while loading
			done_low_r   <= (state_nxt == ST_POR) | (state_nxt == ST_CLEAR) |
				(state_nxt == ST_LOAD) | (state_nxt == ST_ERROR);
			// (RULE9) init-done held low
			init_low_r   <= opt_r[OPT_INIT_DONE_BIT] & (state_nxt != ST_USER) &
				(state_nxt != ST_CLEAR);
			user_r       <= (state_nxt == ST_USER);
			// (RULE8) data pin as user pin
			dout_r       <= i_user_data_out;
			doe_r        <= (state_nxt == ST_USER) & opt_r[OPT_DATA_USER_BIT] &
				i_user_data_oe;
		end
	end

	assign o_status_out          = 1'b0;
	assign o_status_oe           = status_low_r;
	assign o_done_out            = 1'b0;
	assign o_done_oe             = done_low_r;
	assign o_init_done_out       = 1'b0;
	assign o_init_done_oe        = init_low_r;
	assign o_serial_cfg_data_out = dout_r;
	assign o_serial_cfg_data_oe  = doe_r;
	assign o_user_data_in        = din_sync_r[1];
	assign o_user_mode           = user_r;
endmodule

// >>> hdl/pscl_pkg.sv
// constants and types shared by the passive serial configuration loader
//==================================================================
// Overview of operation
// (RULE1) request line low restarts configuration, always; the sequencer ignores it in ST_POR
// (RULE2) user mode: request, status, done high
// (RULE3) status low throughout power-on-reset delay
// (RULE4) done low until image fully received
// (RULE5) done released only after error-free image
// (RULE6) host gives two falling edges after done
// (RULE7) host keeps serial clock at defined level
// (RULE8) data pin becomes user pin after configuration
// (RULE9) init-done output low until initialization ends
// (RULE10) oscillator init: user mode 175..437 us
// (RULE11) user clock used four serial periods later
// (RULE12) user-clock init lasts 8576 user clock periods
// (RULE13) host waits status high before clocking
// (RULE14) one bit per serial clock rising edge
package pscl_pkg;

	//==============================================================
	// timing, in the printed units
	localparam int CLK_PERIOD_NS   = 4;
	localparam int UM_MIN_US       = 175;
	localparam int UM_MAX_US       = 437;
	localparam int CU_PERIODS      = 4;
	localparam int USR_INIT_CYCLES = 8576;

	// derived cycle counts; least times round up, longest round down
	localparam int UM_MIN_CYC = (UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UM_MAX_CYC = (UM_MAX_US * 1000) / CLK_PERIOD_NS;

	//==============================================================
	// option word, first word of the image
	localparam int OPT_INIT_DONE_BIT = 0;
	localparam int OPT_USER_CLK_BIT  = 1;
	localparam int OPT_DATA_USER_BIT = 2;
	localparam logic [31:0] OPT_RESET = 32'h0000_0000;

	//==============================================================
	// word framing and storage
	localparam int WORD_W     = 32;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [3:0] {
		ST_POR,
		ST_CLEAR,
		ST_LOAD,
		ST_EDGES,
		ST_INIT_OSC,
		ST_INIT_CU,
		ST_INIT_USR,
		ST_USER,
		ST_ERROR
	} pscl_state_t;

endpackage

// >>> verif/pscl_assertions.sv
// checker for the loader's pins and word sink
`timescale 1ns/100ps
module pscl_assertions
	import pscl_pkg::*;
#(
	parameter int POR_CYC = 20,
	parameter int UM_CYC  = 50
) (
	// clock and reset
	input wire logic              i_core_clk,
	input wire logic              i_rst_b,
	// watched ports
	input wire logic              i_cfg_req_b,
	input wire logic              i_word_ready,
	input wire logic              o_status_oe,
	input wire logic              o_done_oe,
	input wire logic              o_init_done_oe,
	input wire logic              o_serial_cfg_data_oe,
	input wire logic              o_word_valid,
	input wire logic [WORD_W-1:0] o_word_data,
	input wire logic              o_user_mode
);
	int por_cnt_r;
	int dn_cnt_r;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// cycles since reset release, and since done was released
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			por_cnt_r <= 0;
			dn_cnt_r  <= 0;
		end else begin
			por_cnt_r <= (por_cnt_r < POR_CYC) ? por_cnt_r + 1 : por_cnt_r;
			dn_cnt_r  <= o_done_oe ? 0 : dn_cnt_r + 1;
		end
	end
	a_user_pins_high: assert property (o_user_mode |-> !o_status_oe && !o_done_oe)
		else $error("status or done pulled low in user mode");
	a_por_status: assert property (por_cnt_r < POR_CYC - 1 |-> o_status_oe)
		else $error("status released inside power-on delay");
	a_por_done: assert property (por_cnt_r < POR_CYC - 1 |-> o_done_oe)
		else $error("done released inside power-on delay");
	a_req_restart: assert property ($fell(i_cfg_req_b) |-> ##[1:6]
		(o_status_oe && o_done_oe && !o_user_mode))
		else $error("request low did not restart loading");
	a_init_wait: assert property ($rose(o_user_mode) |-> dn_cnt_r >= UM_CYC - 2)
		else $error("user mode too soon after done");
	a_init_done_off: assert property (o_user_mode |-> !o_init_done_oe)
		else $error("init-done still low in user mode");
	a_data_user_only: assert property (o_serial_cfg_data_oe |-> o_user_mode)
		else $error("data pin driven outside user mode");
	// cycles with status pulled low, or with request low now or 4 cycles back, are left out
	a_word_hold: assert property (o_word_valid && !i_word_ready && !o_status_oe
		&& $past(i_cfg_req_b, 4) && i_cfg_req_b |=> o_word_valid && $stable(o_word_data))
		else $error("stalled word changed");
	c_user: cover property ($rose(o_user_mode));
	c_stall: cover property (o_word_valid && !i_word_ready);
	c_restart: cover property ($fell(i_cfg_req_b));
endmodule

// >>> verif/pscl_host.sv
// host model: request pin, serial clock and data line
`timescale 1ns/100ps
module pscl_host (
	// host pins
	output logic      o_cfg_req_b,
	output logic      o_sclk,
	output logic      o_sdata,
	// status level seen at the pulled-up pin
	input  wire logic i_status
);
	initial begin
		o_cfg_req_b = 1'b1;
		o_sclk      = 1'b0;
		o_sdata     = 1'b0;
	end
	task automatic restart();
		o_cfg_req_b = 1'b0;
		#100;
		o_cfg_req_b = 1'b1;
		for (int i = 0; i < 500 && i_status !== 1'b1; i++)
			#4;
		#20;
	endtask
	// lsb first, bit set while clock low
	task automatic send_word(input logic [31:0] w);
		for (int i = 0; i < 32; i++) begin
			o_sdata = w[i];
			#6 o_sclk = 1'b1;
			#6 o_sclk = 1'b0;
		end
	endtask
	task automatic trail();
		o_sdata = ~o_sdata; // no stale bit left on the line
		repeat (2) begin
			#6 o_sclk = 1'b1;
			#6 o_sclk = 1'b0;
		end
	endtask
endmodule

// >>> verif/pscl_loader_tb.sv
// self-checking bench for the passive serial loader
`timescale 1ns/100ps
module pscl_loader_tb;
	import pscl_pkg::*;
	localparam int IMW  = 34;
	localparam int PORC = 20;
	localparam int UMC  = 50;
	logic              i_core_clk, i_rst_b, i_word_ready, uclk, uclk_en;
	logic              i_user_data_out, i_user_data_oe, req_b, sclk, sdata, pin;
	logic              st_oe, dn_oe, id_oe, d_out, d_oe, w_valid, u_in, u_mode;
	logic [WORD_W-1:0] w_data;
	logic [2:0]        od;
	logic [WORD_W-1:0] got [$];
	int                fail_count = 0;
	int                compares = 0;
	int                cyc = 0;
	int                dcnt = 0;
	initial begin
		i_core_clk = 1'b0;
		forever #2 i_core_clk = ~i_core_clk;
	end
	initial begin
		uclk = 1'b0;
		forever #20 if (uclk_en) uclk = ~uclk;
	end
	assign pin = d_oe ? d_out : sdata;
	pscl_loader #(.IMAGE_WORDS(IMW), .POR_CYC(PORC), .UM_CYC(UMC), .USR_INIT_CYC(8)) u_dut (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cfg_req_b(req_b),
		.i_serial_cfg_clock(sclk), .i_serial_cfg_data_in(pin),
		.o_serial_cfg_data_out(d_out), .o_serial_cfg_data_oe(d_oe),
		.i_user_init_clock(uclk), .o_status_out(od[0]), .o_status_oe(st_oe),
		.o_done_out(od[1]), .o_done_oe(dn_oe), .o_init_done_out(od[2]),
		.o_init_done_oe(id_oe),
		.o_word_valid(w_valid), .i_word_ready(i_word_ready), .o_word_data(w_data),
		.i_user_data_out(i_user_data_out), .i_user_data_oe(i_user_data_oe),
		.o_user_data_in(u_in), .o_user_mode(u_mode));
	pscl_host u_host (.o_cfg_req_b(req_b), .o_sclk(sclk), .o_sdata(sdata), .i_status(~st_oe));
	// sink capture, cycles since done release, hang guard
	always @(posedge i_core_clk) begin
		if (w_valid && i_word_ready)
			got.push_back(w_data);
		dcnt <= dn_oe ? 0 : dcnt + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// sink stalls for the first stall words so they queue up, then drains from just before word stall is sent
	task automatic load(input logic [31:0] opt, input int stall);
		got.delete();
		u_host.restart();
		@(posedge i_core_clk) i_word_ready <= 1'b0;
		for (int i = 0; i < IMW; i++) begin
			if (i == stall)
				@(posedge i_core_clk) i_word_ready <= 1'b1;
			u_host.send_word(i == 0 ? opt : 32'ha5c3_0000 + i);
		end
	endtask
	task automatic finish_load(output int t);
		// trailing edges only after done release
		@(negedge i_core_clk);
		for (int n = 0; n < 500 && dn_oe !== 1'b0; n++)
			@(negedge i_core_clk);
		u_host.trail();
		for (int n = 0; n < 3000 && u_mode !== 1'b1; n++)
			@(negedge i_core_clk);
		t = dcnt;
	endtask
	task automatic t_por();
		repeat (PORC - 3) @(negedge i_core_clk);
		chk("status_oe", 1, st_oe);
		chk("done_oe", 1, dn_oe);
		chk("od_out", 0, od);
	endtask
	task automatic t_osc();
		int t;
		load(32'h0000_0005, 20);
		chk("init_done_oe", 1, id_oe);
		chk("done_oe", 1, dn_oe);
		finish_load(t);
		chk("words", IMW, got.size());
		chk("opt word", 32'h0000_0005, got[0]);
		for (int i = 1; i < IMW; i++)
			chk("word", 32'ha5c3_0000 + i, got[i]);
		chk("osc early", 1, t >= UMC);
		chk("osc late", 1, t <= UMC * 437 / 175);
		chk("user pins", 4'b0001, {st_oe, dn_oe, id_oe, u_mode});
		@(posedge i_core_clk) i_user_data_oe <= 1'b1;
		i_user_data_out <= 1'b1;
		repeat (4) @(negedge i_core_clk);
		chk("data pin", 3'b111, {d_oe, d_out, u_in});
	endtask
	task automatic t_restart();
		fork
			u_host.restart();
			begin
				repeat (10) @(negedge i_core_clk);
				chk("restart", 4'b1100, {st_oe, dn_oe, u_mode, d_oe});
			end
		join
		@(posedge i_core_clk) i_user_data_oe <= 1'b0;
	endtask
	task automatic t_uclk();
		int t;
		uclk_en = 1'b1;
		load(32'h0000_0002, 0);
		chk("init_done_oe", 0, id_oe);
		finish_load(t);
		chk("uclk wait", 1, t >= 75);
		uclk_en = 1'b0;
	endtask
	task automatic t_ovf();
		load(32'h0000_0000, IMW);
		repeat (8) @(negedge i_core_clk);
		chk("overflow", 3'b111, {st_oe, dn_oe, w_valid});
		@(posedge i_core_clk) i_word_ready <= 1'b1;
	endtask
	initial begin
		i_rst_b = 1'b0;
		i_word_ready = 1'b1;
		uclk_en = 1'b0;
		i_user_data_out = 1'b0;
		i_user_data_oe = 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		t_por();
		t_osc();
		t_restart();
		t_uclk();
		t_ovf();
		wrap_up();
	end
endmodule
bind pscl_loader pscl_assertions #(.POR_CYC(POR_CYC), .UM_CYC(UM_CYC)) u_chk (
	.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cfg_req_b(i_cfg_req_b),
	.i_word_ready(i_word_ready), .o_status_oe(o_status_oe), .o_done_oe(o_done_oe),
	.o_init_done_oe(o_init_done_oe), .o_serial_cfg_data_oe(o_serial_cfg_data_oe),
	.o_word_valid(o_word_valid), .o_word_data(o_word_data), .o_user_mode(o_user_mode));
